// ### core/spimsp_pkg.sv
// Constants, types and divider table of the SPI master/slave port.
// Assumes one system clock; the registers are reached over AHB-Lite.
package spimsp_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] CTRL_IDX = 16'h2540;
  localparam logic [15:0] STAT_IDX = 16'h2541;
  localparam logic [15:0] DATA_IDX = 16'h2542;
  localparam logic [15:0] EXT_IDX  = 16'h2543;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_IE  = 7;
  localparam int CTRL_EN  = 6;
  localparam int CTRL_MS  = 4;
  localparam int CTRL_POL = 3;
  localparam int CTRL_PHA = 2;
  localparam int STAT_DONE = 7;
  localparam int STAT_COL  = 6;
  localparam int EXT_CNT   = 6;
  localparam logic [7:0] CTRL_RST  = 8'h10;
  localparam logic [7:0] EXT_RST   = 8'h02;
  localparam logic [7:0] CTRL_MASK = 8'hdf;
  localparam logic [7:0] EXT_MASK  = 8'hc3;

  // ---------------------------------------------------------------
  // FIFOs and bus
  // ---------------------------------------------------------------
  localparam int         FIFO_AW    = 2;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [1:0] HTRANS_NSQ = 2'h2;

  typedef enum logic {ENG_IDLE, ENG_RUN} spimsp_eng_type;

  // Half period in system clocks for the four-bit rate code
  function automatic logic [11:0] spimsp_half(input logic [3:0] code);
    unique case (code)
      4'h3:    spimsp_half = 12'h010;
      4'h4:    spimsp_half = 12'h020;
      4'h5:    spimsp_half = 12'h008;
      4'h6:    spimsp_half = 12'h040;
      4'h7:    spimsp_half = 12'h080;
      4'h8:    spimsp_half = 12'h100;
      4'h9:    spimsp_half = 12'h200;
      4'ha:    spimsp_half = 12'h400;
      4'hb:    spimsp_half = 12'h800;
      default: spimsp_half = 12'h004;
    endcase
  endfunction : spimsp_half

endpackage : spimsp_pkg

// ### core/spimsp_top.sv
// SPI master/slave port with control, status and data registers.
// Assumes an AHB-Lite master on hclk and a peer on the SPI pins.
// What this block does
// - Every byte shifts out and in at the same time.
// - Master mode: writing the data buffer starts a transfer.
// - After done, reading the data buffer gives the received byte.
// - Writes go to a transmit FIFO, reads come from a receive FIFO.
// - Slave mode: sends the byte written before the master clocks.
// - Slave mode: with no byte loaded, master clocks are ignored.
// - Slave mode: received byte readable when done is raised.
// - Control bit 7 enables the interrupt; resets to 0.
// - Control bit 6 enables the port; resets to 0.
// - Control bit 4 selects master when 1; resets to 1.
// - Control bit 3 gives the idle level of the serial clock.
// - Polarity/phase pair picks the data transition edge.
// - Slave, polarity equal phase: change on fall, capture on rise.
// - Slave, polarity unlike phase: change on rise, capture on fall.
// - Control bits 1:0 with extended bits select master clock rate.
// - Status bit 7 set per byte, sticky, drives interrupt.
// - Status bit 6 set on data write with transmit FIFO full.
// - Status bits 3..0: tx full, tx empty, rx full, rx empty.
// - Four-bit rate code maps to system clock dividers 8..4096.
// - Extended byte count plus one gives bytes per master burst.
//
// Local design decision: the AHB-Lite slave port.
module spimsp_top
  import spimsp_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Serial clock pin
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  // Master-out pin
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_n,
  // Master-in pin
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_n,
  // Interrupt request
  output logic             spi_irq
);
  import spimsp_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        ctrl;
    logic [7:0]        ext;
    logic              done;
    logic              col;
    spimsp_eng_type    eng;
    logic [7:0]        tx_sh;
    logic [7:0]        rx_sh;
    logic [2:0]        bitn;
    logic [1:0]        left;
    logic [10:0]       div;
    logic              sck;
    logic [2:0]        s1;
    logic [2:0]        s2;
    logic [2:0]        s3;
    logic [2:0]        f;
    logic [3:0][7:0]   txm;
    logic [FIFO_AW:0]  tx_wp;
    logic [FIFO_AW:0]  tx_rp;
    logic [3:0][7:0]   rxm;
    logic [FIFO_AW:0]  rx_wp;
    logic [FIFO_AW:0]  rx_rp;
    logic              ap_v;
    logic [1:0]        ap_r;
    logic [7:0]        rdat;
  } spimsp_st_type;

  spimsp_st_type q;
  spimsp_st_type d;

  logic [2:0]  tx_cnt;
  logic [2:0]  rx_cnt;
  logic        txf;
  logic        txe;
  logic        rxf;
  logic        rxe;
  logic        en;
  logic        ms;
  logic        pol;
  logic        pha;
  logic [11:0] half;
  logic        hit;
  logic        lead;
  logic        trail;
  logic        sin;
  logic        load;
  logic        byte_done;
  logic        wr_data;

  assign tx_cnt = q.tx_wp - q.tx_rp;
  assign rx_cnt = q.rx_wp - q.rx_rp;
  assign txf    = (tx_cnt == FIFO_DEPTH);
  assign txe    = (tx_cnt == 3'h0);
  assign rxf    = (rx_cnt == FIFO_DEPTH);
  assign rxe    = (rx_cnt == 3'h0);
  assign en     = q.ctrl[CTRL_EN];
  assign ms     = q.ctrl[CTRL_MS];
  assign pol    = q.ctrl[CTRL_POL];
  assign pha    = q.ctrl[CTRL_PHA];
  assign half   = spimsp_half({q.ext[1:0], q.ctrl[1:0]});
  assign hit    = (haddr[31:4] == {14'h0, CTRL_IDX[15:2]})
                  && (haddr[1:0] == 2'h0);
  assign wr_data = q.ap_v && (q.ap_r == DATA_IDX[1:0]);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d         = q;
    lead      = 1'b0;
    trail     = 1'b0;
    load      = 1'b0;
    byte_done = 1'b0;
    // Pin synchronisers, change counts once stages two and three agree
    d.s1 = {sck_in, mosi_in, miso_in};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.f  = (q.s2 & q.s3) | (q.f & (q.s2 | q.s3));
    // Agreed value used at once: one more flop would make the master
    // sample the previous bit at the fastest rate
    sin  = ms ? d.f[0] : d.f[1];

    // Address phase; reads answer from registered data
    d.ap_v = 1'b0;
    if (hsel && hready && htrans == HTRANS_NSQ) begin
      d.ap_v = hwrite && hit;
      d.ap_r = haddr[3:2];
      d.rdat = 8'h00;
      if (!hwrite && hit) begin
        unique case (haddr[3:2])
          2'h0: d.rdat = q.ctrl;
          2'h1: d.rdat = {q.done, q.col, 2'h0, txf, txe, rxf, rxe};
          2'h2: begin
            if (!rxe) begin
              d.rdat  = q.rxm[q.rx_rp[FIFO_AW-1:0]];
              d.rx_rp = q.rx_rp + 3'h1;
            end
          end
          2'h3: d.rdat = q.ext;
        endcase
      end
    end

    // Data phase writes
    if (q.ap_v) begin
      unique case (q.ap_r)
        2'h0: d.ctrl = hwdata[7:0] & CTRL_MASK;
        2'h1: begin
          d.done = q.done & hwdata[STAT_DONE];
          d.col  = q.col & hwdata[STAT_COL];
        end
        2'h2: begin
          if (txf) begin
            d.col = 1'b1;
          end else begin
            d.txm[q.tx_wp[FIFO_AW-1:0]] = hwdata[7:0];
            d.tx_wp = q.tx_wp + 3'h1;
          end
        end
        2'h3: d.ext = hwdata[7:0] & EXT_MASK;
      endcase
    end

    // Transfer engine
    unique case (q.eng)
      ENG_IDLE: begin
        d.sck = pol;
        // Slave waits here without a byte, so clocks are ignored
        if (en && !txe) begin
          load   = 1'b1;
          d.left = ms ? q.ext[EXT_CNT+1:EXT_CNT] : 2'h0;
        end
      end
      ENG_RUN: begin
        if (!en) begin
          d.eng = ENG_IDLE;
        end else if (ms) begin
          if ({1'b0, q.div} == half - 12'h001) begin
            d.div = 11'h000;
            d.sck = ~q.sck;
            lead  = (q.sck == pol);
            trail = (q.sck != pol);
          end else begin
            d.div = q.div + 11'h001;
          end
        end else begin
          // Edges of the external clock only, never driven here
          lead  = (d.f[2] != q.f[2]) && (d.f[2] != pol);
          trail = (d.f[2] != q.f[2]) && (d.f[2] == pol);
        end
        // Phase 0 samples on leading and shifts on trailing
        if (lead) begin
          if (!pha) begin
            d.rx_sh = {q.rx_sh[6:0], sin};
          end else if (q.bitn != 3'h0) begin
            d.tx_sh = {q.tx_sh[6:0], 1'b0};
          end
        end
        if (trail) begin
          if (pha) begin
            d.rx_sh = {q.rx_sh[6:0], sin};
          end else begin
            d.tx_sh = {q.tx_sh[6:0], 1'b0};
          end
          d.bitn = q.bitn + 3'h1;
          if (q.bitn == 3'h7) begin
            byte_done = 1'b1;
          end
        end
        if (byte_done) begin
          d.done = 1'b1;
          if (!rxf) begin
            d.rxm[q.rx_wp[FIFO_AW-1:0]] = d.rx_sh;
            d.rx_wp = q.rx_wp + 3'h1;
          end
          if (ms && q.left != 2'h0 && !txe) begin
            load   = 1'b1;
            d.left = q.left - 2'h1;
          end else begin
            d.eng = ENG_IDLE;
          end
        end
      end
    endcase

    if (load) begin
      d.eng   = ENG_RUN;
      d.tx_sh = q.txm[q.tx_rp[FIFO_AW-1:0]];
      d.tx_rp = q.tx_rp + 3'h1;
      d.bitn  = 3'h0;
      d.div   = 11'h000;
      d.sck   = pol;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q      <= '0;
      q.ctrl <= CTRL_RST;
      q.ext  <= EXT_RST;
      q.eng  <= ENG_IDLE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = {24'h0, q.rdat};
  assign sck_out   = q.sck;
  assign sck_oe_n  = !(en && ms);
  assign mosi_out  = q.tx_sh[7];
  assign mosi_oe_n = !(en && ms);
  assign miso_out  = q.tx_sh[7];
  assign miso_oe_n = !(en && !ms && q.eng == ENG_RUN);
  assign spi_irq   = q.ctrl[CTRL_IE] && q.done;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_idle_level;
    (q.eng == ENG_IDLE) && $past(q.eng == ENG_IDLE) && $stable(pol)
      |-> sck_out == pol;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("serial clock not at idle level");

  property p_done_set;
    byte_done |=> q.done && !rxe;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag or rx data missing after byte");

  property p_collision;
    wr_data && txf |=> q.col;
  endproperty
  a_collision: assert property (p_collision)
    else $error("write collision not flagged");

  property p_tx_push;
    wr_data && !txf |=> !txe || (q.eng == ENG_RUN);
  endproperty
  a_tx_push: assert property (p_tx_push)
    else $error("written byte lost");

  property p_irq_gate;
    !q.ctrl[CTRL_IE] |-> !spi_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt not gated by enable");

  property p_slave_quiet;
    !ms && (q.eng == ENG_IDLE) |-> miso_oe_n;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("slave drives data with no byte loaded");

  property p_slave_no_sck;
    !ms |-> sck_oe_n;
  endproperty
  a_slave_no_sck: assert property (p_slave_no_sck)
    else $error("slave drives serial clock");

  property p_rate8;
    ms && (q.eng == ENG_RUN) && $changed(sck_out) && en
      && ({q.ext[1:0], q.ctrl[1:0]} == 4'h2) && !load
      |=> $stable(sck_out)[*3];
  endproperty
  a_rate8: assert property (p_rate8)
    else $error("divide-by-8 half period wrong");

  property p_start;
    en && ms && (q.eng == ENG_IDLE) && wr_data && !txf
      |-> ##[1:2] (q.eng == ENG_RUN);
  endproperty
  a_start: assert property (p_start)
    else $error("master write did not start a transfer");

  property p_en_off;
    !en |=> q.eng == ENG_IDLE;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("engine runs while port disabled");

  property p_master_drive;
    en && ms |-> !sck_oe_n && !mosi_oe_n && miso_oe_n;
  endproperty
  a_master_drive: assert property (p_master_drive)
    else $error("master does not own clock and data out");

  property p_slave_ignore;
    !ms && (q.eng == ENG_IDLE) && txe |=> q.eng == ENG_IDLE;
  endproperty
  a_slave_ignore: assert property (p_slave_ignore)
    else $error("slave started with no byte loaded");

  property p_slave_load;
    !ms && en && (q.eng == ENG_IDLE) && !txe && !q.ap_v
      |=> (q.eng == ENG_RUN) && !miso_oe_n;
  endproperty
  a_slave_load: assert property (p_slave_load)
    else $error("loaded byte not presented to master");

  c_master: cover property (ms && byte_done);
  c_slave: cover property (!ms && byte_done);
  c_collision: cover property (wr_data && txf);
  c_burst: cover property (ms && byte_done && load);

endmodule : spimsp_top

// ### sim/spimsp_peer.sv
// Behavioural SPI peer: slave to the port in master mode, master to it
// in slave mode. Assumes the bench resolves the shared pins.
module spimsp_peer (
  // Clock and role
  input  wire logic       clk,
  input  wire logic       as_master,
  input  wire logic       cpol,
  input  wire logic       cpha,
  // Resolved pins
  input  wire logic       sck_line,
  input  wire logic       mosi_line,
  input  wire logic       miso_line,
  // Peer drivers and received byte
  output logic            sck_drv,
  output logic            mosi_drv,
  output logic            miso_drv,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 6;
  logic [7:0] sh;
  int         n = 8;
  initial begin
    sck_drv = 1'b0;
    mosi_drv = 1'b0;
    miso_drv = 1'b0;
  end

  task automatic load(input logic [7:0] b);
    sh = b;
    n = 0;
    miso_drv = b[7];
  endtask : load

  // -------------------------------------------------------------
  // Slave role: sample on the edge opposite the data transition
  // -------------------------------------------------------------
  always @(sck_line) begin
    if (!as_master && n < 8) begin
      if ((sck_line != cpol) ^ cpha) begin
        rx = {rx[6:0], mosi_line};
        n++;
      end else if (n > 0) begin
        sh = sh << 1;
        miso_drv = sh[7];
      end
    end
  end
  // Released line shows a changing pattern
  always @(negedge clk) begin
    if (!as_master && n == 8) miso_drv <= ~miso_drv;
  end

  // -------------------------------------------------------------
  // Master role: one byte, MSB first, clock still outside frames
  // -------------------------------------------------------------
  task automatic frame(input logic [7:0] b);
    sh = b;
    repeat (8) begin
      if (!cpha) mosi_drv <= sh[7];
      repeat (HALF) @(posedge clk);
      sck_drv <= ~cpol;
      if (cpha) mosi_drv <= sh[7];
      else rx = {rx[6:0], miso_line};
      repeat (HALF) @(posedge clk);
      sck_drv <= cpol;
      if (cpha) rx = {rx[6:0], miso_line};
      sh = sh << 1;
    end
    repeat (HALF) @(posedge clk);
    mosi_drv <= ~mosi_drv;
    @(posedge clk);
  endtask : frame
endmodule : spimsp_peer

// ### sim/tb_top.sv
// Self-checking bench of the SPI port: registers over AHB-Lite,
// transfers against the peer. Assumes a 50 MHz hclk.
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb_top;
  import spimsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  logic        p_sck, p_mosi, p_miso, sck_line, mosi_line, miso_line;
  logic        spi_irq, as_master, cpol, cpha;
  logic [7:0]  prx, rd, tb_b [4], pb [4];
  logic [3:0]  codes [4] = '{4'h2, 4'h5, 4'h3, 4'h4};
  int          fail_count, compares, seed;

  assign hready = hreadyout;
  assign sck_line = sck_oe_n ? p_sck : sck_out;
  assign mosi_line = mosi_oe_n ? p_mosi : mosi_out;
  assign miso_line = miso_oe_n ? p_miso : miso_out;

  spimsp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sck_in(sck_line),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_line),
    .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_line),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .spi_irq(spi_irq));
  spimsp_peer peer (.clk(hclk), .as_master(as_master), .cpol(cpol),
    .cpha(cpha), .sck_line(sck_line), .mosi_line(mosi_line),
    .miso_line(miso_line), .sck_drv(p_sck), .mosi_drv(p_mosi),
    .miso_drv(p_miso), .rx(prx));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // -------------------------------------------------------------
  // Bus and check tasks
  // -------------------------------------------------------------
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [7:0] wd, output logic [7:0] q);
    int n = 0;
    hsel <= 1'b1;
    htrans <= HTRANS_NSQ;
    haddr <= {14'h0000, idx, 2'h0};
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 99);
    q = hrdata[7:0];
    if (n >= 99) fail_count++;
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic chk_reg(input string nm, input logic [15:0] idx,
                         input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    `CHK(nm, e, q)
  endtask : chk_reg

  task automatic wait_done();
    logic [7:0] q;
    int n = 0;
    do begin bus(1'b0, STAT_IDX, 8'h00, q); n++; end
    while (q[7] !== 1'b1 && n < 400);
    if (n >= 400) fail_count++;
  endtask : wait_done

  function automatic int exp_half(input logic [3:0] c);
    case (c)
      4'h2: return 4;
      4'h3: return 16;
      4'h4: return 32;
      default: return 8;
    endcase
  endfunction : exp_half

  task automatic master_xfer(input logic [1:0] m, input logic [3:0] c,
                             input logic ie);
    logic [7:0] b, p;
    int n;
    b = $random(seed);
    p = $random(seed);
    {cpol, cpha} = m;
    as_master = 1'b0;
    wr(EXT_IDX, {6'h00, c[3:2]});
    wr(CTRL_IDX, {ie, 3'h5, m, c[1:0]});
    repeat (3) @(posedge hclk);
    `CHK("idle sck", m[1], sck_out)
    peer.load(p);
    wr(DATA_IDX, b);
    n = 0;
    while (sck_out === m[1] && n < 99) begin @(posedge hclk); n++; end
    n = 0;
    while (sck_out !== m[1] && n < 99) begin @(posedge hclk); n++; end
    `CHK("half period", exp_half(c), n)
    wait_done();
    `CHK("irq", ie, spi_irq)
    chk_reg("rx data", DATA_IDX, p);
    `CHK("peer rx", b, prx)
    wr(STAT_IDX, 8'h00);
    chk_reg("done clear", STAT_IDX, 8'h05);
  endtask : master_xfer

  task automatic final_report();
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  initial begin
    repeat (30000) @(posedge hclk);
    fail_count++;
    final_report();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    {seed, fail_count, compares} = {32'd37, 64'd0};
    {hresetn, hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = 3'h2;
    {as_master, cpol, cpha} = 3'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_reg("ctrl rst", CTRL_IDX, 8'h10);
    chk_reg("stat rst", STAT_IDX, 8'h05);
    chk_reg("ext rst", EXT_IDX, 8'h02);
    chk_reg("unmapped", 16'h2544, 8'h00);
    wr(STAT_IDX, 8'hff);
    chk_reg("stat ro", STAT_IDX, 8'h05);
    repeat (4) begin
      rd = $random(seed);
      wr(CTRL_IDX, rd);
      chk_reg("ctrl rw", CTRL_IDX, rd & 8'hdf);
    end
    wr(EXT_IDX, 8'h02);
    wr(CTRL_IDX, 8'h10);
    foreach (tb_b[i]) begin
      tb_b[i] = $random(seed);
      wr(DATA_IDX, tb_b[i]);
    end
    wr(DATA_IDX, 8'h5a);
    chk_reg("fifo full", STAT_IDX, 8'h49);
    wr(STAT_IDX, 8'h00);
    chk_reg("col clear", STAT_IDX, 8'h09);
    as_master = 1'b1;
    wr(CTRL_IDX, 8'h40);
    foreach (pb[i]) begin
      pb[i] = $random(seed);
      peer.frame(pb[i]);
      `CHK("slave tx", tb_b[i], prx)
    end
    repeat (8) @(posedge hclk);
    chk_reg("rx full", STAT_IDX, 8'h86);
    foreach (pb[i]) chk_reg("slave rx", DATA_IDX, pb[i]);
    wr(STAT_IDX, 8'h00);
    peer.frame(8'hc3);
    repeat (8) @(posedge hclk);
    chk_reg("no load", STAT_IDX, 8'h05);
    for (int i = 0; i < 4; i++) begin
      master_xfer(2'(i), codes[i], i[0]);
    end
    final_report();
  end
endmodule : tb_top
